// >>> core/ldwf_pkg.sv
// Package: constants, types and register map of the line driver control
package ldwf_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int PULSE_QUAL_TIME_US = 80;
   localparam int PULSE_QUAL_CYC = PULSE_QUAL_TIME_US * (CLK_HZ / 1_000_000);
   localparam int OVERLOAD_REPORT_TIME_US = 200;
   localparam int OVERLOAD_REPORT_CYC =
      OVERLOAD_REPORT_TIME_US * (CLK_HZ / 1_000_000);
   localparam int WAKE_TOL_PCT = 25;
   localparam int WAKE_MIN_CYC = PULSE_QUAL_CYC * (100 - WAKE_TOL_PCT) / 100;
   localparam int WAKE_MAX_CYC = PULSE_QUAL_CYC * (100 + WAKE_TOL_PCT) / 100;
   localparam int CNT_W = 24;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_EN_OFS = 8'h0C;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
   localparam logic [7:0] WAKE_MIN_OFS = 8'h14;
   localparam logic [7:0] WAKE_MAX_OFS = 8'h18;
   localparam logic [7:0] LIMIT_QUAL_OFS = 8'h1C;
   localparam logic [7:0] SHORT_QUAL_OFS = 8'h20;

   // CTRL fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LEVEL_BIT = 1;
   localparam int CTRL_PP_BIT = 2;
   localparam logic [31:0] CTRL_RST = 32'h0000_0002;

   // STATUS / IRQ fields (same layout)
   localparam int ST_WAKE_BIT = 0;
   localparam int ST_LIMIT_BIT = 1;
   localparam int ST_SHORT_BIT = 2;
   localparam int ST_OVERTEMP_BIT = 3;
   localparam int ST_TEMP_OK_BIT = 4;
   localparam int ST_DRV_ON_BIT = 5;
   localparam int IRQ_W = 4;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LDWF_DRV_HIZ  = 2'b00,
      LDWF_DRV_SINK = 2'b01,
      LDWF_DRV_SRC  = 2'b10
   } ldwf_drv_t;

   typedef struct packed {
      logic sink_on;
      logic src_on;
   } ldwf_line_drv_t;

   typedef struct packed {
      logic wake_out_n;
      logic wake_oe;
      logic limit_flag_n;
      logic limit_oe;
      logic short_circuit_flag;
      logic short_oe;
      logic temp_ok_n;
      logic temp_oe;
   } ldwf_od_t;

endpackage

// >>> core/ldwf_timer.sv
// Duration counter: measures how long a level has been high
`timescale 1ns/1ps
`default_nettype none
module ldwf_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level,
   output logic [ldwf_pkg::CNT_W-1:0] count,
   output logic fell,
   output logic [ldwf_pkg::CNT_W-1:0] last_len
);
   logic level_reg;

   // ------------------------------------------------------------
   // Saturating count while high
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (!level) begin
         count <= '0;
      end else if (count != {ldwf_pkg::CNT_W{1'b1}}) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_reg <= 1'b0;
         fell <= 1'b0;
         last_len <= '0;
      end else begin
         level_reg <= level;
         fell <= level_reg && !level;
         if (level_reg && !level) begin
            last_len <= count;
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/ldwf_core.sv
// Line driver control, wake detection and fault reporting with AXI4-Lite
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ldwf_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_io_in,
   input wire logic at_limit,
   input wire logic over_temp,
   input wire logic temp_warn,
   output logic line_sink_on,
   output logic line_src_on,
   output logic regulator_en,
   output logic wake_out_n_o,
   output logic wake_out_oe,
   output logic limit_flag_n_o,
   output logic limit_flag_n_oe,
   output logic short_circuit_flag_o,
   output logic short_circuit_flag_oe,
   output logic temp_ok_n_o,
   output logic temp_ok_n_oe,
   output logic irq
);
   logic [31:0] ctrl_reg;
   logic [ldwf_pkg::CNT_W-1:0] wake_min_reg;
   logic [ldwf_pkg::CNT_W-1:0] wake_max_reg;
   logic [ldwf_pkg::CNT_W-1:0] limit_qual_reg;
   logic [ldwf_pkg::CNT_W-1:0] short_qual_reg;
   logic [ldwf_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [ldwf_pkg::IRQ_W-1:0] irq_stat_next;
   logic [ldwf_pkg::IRQ_W-1:0] irq_en_reg;
   logic [ldwf_pkg::IRQ_W-1:0] irq_clr;
   logic [ldwf_pkg::CNT_W-1:0] lim_count;
   logic [ldwf_pkg::CNT_W-1:0] lim_len;
   logic lim_fell;
   logic wake_pulse;
   logic wake_reg;
   logic limit_reg;
   logic short_reg;
   logic otp_reg;
   logic temp_ok_reg;
   logic otp_fall;
   ldwf_pkg::ldwf_drv_t drv_next;
   ldwf_pkg::ldwf_line_drv_t drv_reg;
   ldwf_pkg::ldwf_od_t od;
   logic line_io_reg;

   logic [7:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_have_reg;
   logic wr_fire;
   logic wr_ok;

   // Byte-lane merge, used by every writable register except the one at IRQ_CLR_OFS
   function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return a == ldwf_pkg::CTRL_OFS || a == ldwf_pkg::STATUS_OFS ||
             a == ldwf_pkg::IRQ_STAT_OFS || a == ldwf_pkg::IRQ_EN_OFS ||
             a == ldwf_pkg::IRQ_CLR_OFS || a == ldwf_pkg::WAKE_MIN_OFS ||
             a == ldwf_pkg::WAKE_MAX_OFS || a == ldwf_pkg::LIMIT_QUAL_OFS ||
             a == ldwf_pkg::SHORT_QUAL_OFS;
   endfunction

   // ------------------------------------------------------------
   // Driver mode decode
   // ------------------------------------------------------------
   always_comb begin
      drv_next = ldwf_pkg::LDWF_DRV_HIZ;
      // Thermal shutdown overrides the inputs; on cooling they rule again
      if (!otp_reg && ctrl_reg[ldwf_pkg::CTRL_EN_BIT]) begin
         if (ctrl_reg[ldwf_pkg::CTRL_LEVEL_BIT]) begin
            drv_next = ldwf_pkg::LDWF_DRV_SINK;
         end else begin
            drv_next = ldwf_pkg::LDWF_DRV_SRC;
         end
      end
   end

   // Push-pull and switch modes share one truth table; the mode bit only
   // tells the wake detector that the node is already communicating
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv_reg <= '0;
      end else begin
         drv_reg.sink_on <= drv_next == ldwf_pkg::LDWF_DRV_SINK;
         drv_reg.src_on <= drv_next == ldwf_pkg::LDWF_DRV_SRC;
      end
   end

   // ------------------------------------------------------------
   // Thermal supervision
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         otp_reg <= 1'b0;
         temp_ok_reg <= 1'b0;
      end else begin
         otp_reg <= over_temp;
         // Re-enable follows over_temp alone; temperature-good also waits for temp_warn low
         if (otp_fall) begin
            temp_ok_reg <= 1'b0;
         end else begin
            temp_ok_reg <= !temp_warn && !over_temp;
         end
      end
   end
   assign otp_fall = otp_reg && !over_temp;

   // ------------------------------------------------------------
   // Limit duration measurement
   // ------------------------------------------------------------
   ldwf_timer u_lim_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(at_limit),
      .count(lim_count),
      .fell(lim_fell),
      .last_len(lim_len)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_io_reg <= 1'b0;
      end else begin
         line_io_reg <= line_io_in;
      end
   end

   // A wake is a limit episode whose length falls inside the window
   assign wake_pulse = lim_fell && !ctrl_reg[ldwf_pkg::CTRL_PP_BIT] &&
                       lim_len >= wake_min_reg &&
                       lim_len <= wake_max_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_reg <= 1'b0;
      end else if (wake_pulse) begin
         wake_reg <= 1'b1;
      end else if (irq_clr[ldwf_pkg::ST_WAKE_BIT]) begin
         // Held until software acknowledges; receive switch is its job
         wake_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         limit_reg <= 1'b0;
         short_reg <= 1'b0;
      end else begin
         limit_reg <= at_limit && lim_count > limit_qual_reg;
         short_reg <= at_limit && lim_count > short_qual_reg;
      end
   end

   // ------------------------------------------------------------
   // Open-drain status outputs
   // ------------------------------------------------------------
   always_comb begin
      od.wake_out_n = 1'b0;
      od.wake_oe = wake_reg;
      od.limit_flag_n = 1'b0;
      od.limit_oe = limit_reg;
      od.short_circuit_flag = 1'b0;
      od.short_oe = short_reg;
      od.temp_ok_n = 1'b0;
      od.temp_oe = temp_ok_reg;
   end

   assign wake_out_n_o = od.wake_out_n;
   assign wake_out_oe = od.wake_oe;
   assign limit_flag_n_o = od.limit_flag_n;
   assign limit_flag_n_oe = od.limit_oe;
   assign short_circuit_flag_o = od.short_circuit_flag;
   assign short_circuit_flag_oe = od.short_oe;
   assign temp_ok_n_o = od.temp_ok_n;
   assign temp_ok_n_oe = od.temp_oe;
   assign line_sink_on = drv_reg.sink_on;
   assign line_src_on = drv_reg.src_on;
   assign regulator_en = !otp_reg;

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   always_comb begin
      irq_stat_next = irq_stat_reg & ~irq_clr;
      // Set beats clear in the same cycle
      if (wake_pulse) irq_stat_next[ldwf_pkg::ST_WAKE_BIT] = 1'b1;
      if (at_limit && lim_count == limit_qual_reg)
         irq_stat_next[ldwf_pkg::ST_LIMIT_BIT] = 1'b1;
      if (at_limit && lim_count == short_qual_reg)
         irq_stat_next[ldwf_pkg::ST_SHORT_BIT] = 1'b1;
      if (over_temp && !otp_reg)
         irq_stat_next[ldwf_pkg::ST_OVERTEMP_BIT] = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_en_reg);
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign wr_fire = aw_have_reg && w_have_reg;
   assign wr_ok = addr_ok(aw_addr_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ldwf_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? ldwf_pkg::RESP_OKAY : ldwf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign irq_clr = (wr_fire && aw_addr_reg == ldwf_pkg::IRQ_CLR_OFS &&
                     w_strb_reg[0]) ? w_data_reg[ldwf_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= ldwf_pkg::CTRL_RST;
         irq_en_reg <= '0;
         wake_min_reg <= ldwf_pkg::CNT_W'(ldwf_pkg::WAKE_MIN_CYC);
         wake_max_reg <= ldwf_pkg::CNT_W'(ldwf_pkg::WAKE_MAX_CYC);
         limit_qual_reg <= ldwf_pkg::CNT_W'(ldwf_pkg::PULSE_QUAL_CYC);
         short_qual_reg <= ldwf_pkg::CNT_W'(ldwf_pkg::OVERLOAD_REPORT_CYC);
      end else if (wr_fire) begin
         unique case (aw_addr_reg)
            ldwf_pkg::CTRL_OFS: begin
               ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) &
                           32'h0000_0007;
            end
            ldwf_pkg::IRQ_EN_OFS: begin
               irq_en_reg <= ldwf_pkg::IRQ_W'(merge({28'h000_0000,
                  irq_en_reg}, w_data_reg, w_strb_reg));
            end
            ldwf_pkg::WAKE_MIN_OFS: begin
               wake_min_reg <= ldwf_pkg::CNT_W'(merge({8'h00,
                  wake_min_reg}, w_data_reg, w_strb_reg));
            end
            ldwf_pkg::WAKE_MAX_OFS: begin
               wake_max_reg <= ldwf_pkg::CNT_W'(merge({8'h00,
                  wake_max_reg}, w_data_reg, w_strb_reg));
            end
            ldwf_pkg::LIMIT_QUAL_OFS: begin
               limit_qual_reg <= ldwf_pkg::CNT_W'(merge({8'h00,
                  limit_qual_reg}, w_data_reg, w_strb_reg));
            end
            ldwf_pkg::SHORT_QUAL_OFS: begin
               short_qual_reg <= ldwf_pkg::CNT_W'(merge({8'h00,
                  short_qual_reg}, w_data_reg, w_strb_reg));
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ldwf_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_ok(s_axi_araddr) ? ldwf_pkg::RESP_OKAY :
                        ldwf_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            ldwf_pkg::CTRL_OFS: s_axi_rdata <= ctrl_reg;
            ldwf_pkg::STATUS_OFS: s_axi_rdata <= {26'h000_0000,
               drv_reg.sink_on | drv_reg.src_on, temp_ok_reg, otp_reg,
               short_reg, limit_reg, wake_reg};
            ldwf_pkg::IRQ_STAT_OFS: s_axi_rdata <= {28'h000_0000, irq_stat_reg};
            ldwf_pkg::IRQ_EN_OFS: s_axi_rdata <= {28'h000_0000, irq_en_reg};
            ldwf_pkg::WAKE_MIN_OFS: s_axi_rdata <= {8'h00, wake_min_reg};
            ldwf_pkg::WAKE_MAX_OFS: s_axi_rdata <= {8'h00, wake_max_reg};
            ldwf_pkg::LIMIT_QUAL_OFS: s_axi_rdata <= {8'h00, limit_qual_reg};
            ldwf_pkg::SHORT_QUAL_OFS: s_axi_rdata <= {8'h00, short_qual_reg};
            default: s_axi_rdata <= {31'h0000_0000, line_io_reg};
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/ldwf_master_model.sv
// Far-end master: forces the line with wake or overload current on request
`timescale 1ns/1ps
`default_nettype none
module ldwf_master_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic [15:0] len,
   output wire logic at_limit,
   output wire logic line_io_in
);
   // ------------------------------------------------------------
   // Current episode length
   // ------------------------------------------------------------
   logic [15:0] left_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_reg <= 16'h0000;
      end else if (go) begin
         left_reg <= len;
      end else if (left_reg != 16'h0000) begin
         left_reg <= left_reg - 16'h0001;
      end
   end

   // Line idles high; the master pulls it inverse while forcing current
   assign at_limit = (left_reg != 16'h0000);
   assign line_io_in = ~at_limit;
endmodule
`default_nettype wire

// >>> tb/ldwf_monitor.sv
// Concurrent checks on the ports of the line driver control block
`timescale 1ns/1ps
`default_nettype none
module ldwf_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic at_limit,
   input wire logic over_temp,
   input wire logic temp_warn,
   input wire logic line_sink_on,
   input wire logic line_src_on,
   input wire logic regulator_en,
   input wire logic wake_out_n_o,
   input wire logic wake_out_oe,
   input wire logic limit_flag_n_o,
   input wire logic limit_flag_n_oe,
   input wire logic short_circuit_flag_o,
   input wire logic short_circuit_flag_oe,
   input wire logic temp_ok_n_o,
   input wire logic temp_ok_n_oe
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_one_side;
      !(line_sink_on && line_src_on);
   endproperty
   a_one_side: assert property (p_one_side)
      else $error("sink and source switched on together");

   // Flag may only rise after a long stretch at the limit
   property p_lim_late;
      $rose(limit_flag_n_oe) |-> at_limit && $past(at_limit, 8);
   endproperty
   a_lim_late: assert property (p_lim_late)
      else $error("limit flag rose without a long overload");

   property p_lim_drop;
      !at_limit ##1 !at_limit |-> !limit_flag_n_oe;
   endproperty
   a_lim_drop: assert property (p_lim_drop)
      else $error("limit flag held after overload ended");

   property p_sc_late;
      $rose(short_circuit_flag_oe) |-> at_limit && $past(at_limit, 8);
   endproperty
   a_sc_late: assert property (p_sc_late)
      else $error("short flag rose without a long overload");

   property p_wake_gap;
      $rose(wake_out_oe) |-> !at_limit && !limit_flag_n_oe;
   endproperty
   a_wake_gap: assert property (p_wake_gap)
      else $error("wake raised during an overload");

   property p_od_low;
      !wake_out_n_o && !limit_flag_n_o && !short_circuit_flag_o &&
      !temp_ok_n_o;
   endproperty
   a_od_low: assert property (p_od_low)
      else $error("open drain output drives high");

   property p_ot_off;
      over_temp [*3] |-> !line_sink_on && !line_src_on;
   endproperty
   a_ot_off: assert property (p_ot_off)
      else $error("driver active in over temperature");

   property p_reg_off;
      over_temp |=> !regulator_en;
   endproperty
   a_reg_off: assert property (p_reg_off)
      else $error("regulator on in over temperature");

   property p_reg_on;
      !over_temp |=> regulator_en;
   endproperty
   a_reg_on: assert property (p_reg_on)
      else $error("regulator off after cooling");

   property p_temp;
      temp_warn || over_temp |=> !temp_ok_n_oe;
   endproperty
   a_temp: assert property (p_temp)
      else $error("temperature good shown while hot");

   c_wake: cover property ($rose(wake_out_oe));
   c_short: cover property ($rose(short_circuit_flag_oe));
   c_hot: cover property (over_temp [*3] ##1 !over_temp);
endmodule
`default_nettype wire

bind ldwf_core ldwf_monitor i_ldwf_monitor (.*);

// >>> tb/tb_line_driver_wake_fault_ctrl.sv
// Self-checking bench for the line driver control block
`timescale 1ns/1ps
`default_nettype none
module tb_line_driver_wake_fault_ctrl;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic over_temp = 1'h0, temp_warn = 1'h0, go = 1'h0;
   logic [15:0] len = 16'h0000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, at_limit, line_io_in, line_sink_on, line_src_on;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, rd;
   logic [31:0] lf = 32'h0000_7bcd;
   logic [2:0] c;
   logic regulator_en, irq, wake_out_n_o, wake_out_oe;
   logic limit_flag_n_o, limit_flag_n_oe, temp_ok_n_o, temp_ok_n_oe;
   logic short_circuit_flag_o, short_circuit_flag_oe;
   int err_count = 0, samples_checked = 0, cyc = 0;

   ldwf_core i_ldwf_core (.*);
   ldwf_master_model i_ldwf_master_model (.*);

   initial begin
      forever #10 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected {sink, source}; push-pull shares the switch table
   function automatic logic [31:0] exp_drv(input logic [2:0] v);
      return v[0] ? (v[1] ? 32'h0000_0002 : 32'h0000_0001) : 32'h0000_0000;
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Address and data offered together; each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'h0;
      w = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wready === 1'h1) begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask

   task automatic rd_reg(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask

   task automatic start(input int n);
      len <= n[15:0];
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
   endtask

   task automatic pulse(input int n);
      start(n);
      repeat (n + 6) @(posedge aclk);
   endtask

   // Cuts a hang short; the whole run needs fewer than a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd_reg(ldwf_pkg::CTRL_OFS);
      chk(rd, ldwf_pkg::CTRL_RST);
      chk(32'({line_sink_on, line_src_on}), 32'h0000_0000);
      rd_reg(8'h24);
      chk(32'(rs), 32'(ldwf_pkg::RESP_SLVERR));
      wr(8'h24, 32'hffff_ffff);
      chk(32'(rs), 32'(ldwf_pkg::RESP_SLVERR));
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         lf = lfsr_step(lf);
         c = (i < 8) ? i[2:0] : lf[2:0];
         wr(ldwf_pkg::CTRL_OFS, {29'h0000_0000, c});
         repeat (2) @(posedge aclk);
         chk(32'({line_sink_on, line_src_on}), exp_drv(c));
      end
      $display("test drive modes done");
      // Wake window 20..30 kept under the limit time of 40
      wr(ldwf_pkg::WAKE_MIN_OFS, 32'h0000_0014);
      wr(ldwf_pkg::WAKE_MAX_OFS, 32'h0000_001e);
      wr(ldwf_pkg::LIMIT_QUAL_OFS, 32'h0000_0028);
      wr(ldwf_pkg::SHORT_QUAL_OFS, 32'h0000_003c);
      wr(ldwf_pkg::CTRL_OFS, 32'h0000_0002);
      lf = lfsr_step(lf);
      pulse(22 + int'(lf[2:0]));
      chk(32'(wake_out_oe), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      wr(ldwf_pkg::IRQ_EN_OFS, 32'h0000_000f);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0000_0001);
      rd_reg(ldwf_pkg::IRQ_STAT_OFS);
      chk(rd, 32'h0000_0001);
      wr(ldwf_pkg::IRQ_CLR_OFS, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk(32'({wake_out_oe, irq}), 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         lf = lfsr_step(lf);
         pulse(i < 3 ? 2 + int'(lf[3:0]) : 34 + int'(lf[1:0]));
         chk(32'(wake_out_oe), 32'h0000_0000);
      end
      // Push-pull means already communicating: no wake detection
      wr(ldwf_pkg::CTRL_OFS, 32'h0000_0006);
      pulse(25);
      chk(32'(wake_out_oe), 32'h0000_0000);
      $display("test wake done");
      start(80);
      repeat (30) @(posedge aclk);
      chk(32'(limit_flag_n_oe), 32'h0000_0000);
      repeat (20) @(posedge aclk);
      chk(32'(limit_flag_n_oe), 32'h0000_0001);
      chk(32'(short_circuit_flag_oe), 32'h0000_0000);
      repeat (25) @(posedge aclk);
      chk(32'(short_circuit_flag_oe), 32'h0000_0001);
      repeat (10) @(posedge aclk);
      chk(32'({limit_flag_n_oe, wake_out_oe}), 32'h0000_0000);
      rd_reg(ldwf_pkg::IRQ_STAT_OFS);
      chk(rd, 32'h0000_0006);
      wr(ldwf_pkg::IRQ_CLR_OFS, 32'h0000_000f);
      $display("test overload done");
      wr(ldwf_pkg::CTRL_OFS, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk(32'(temp_ok_n_oe), 32'h0000_0001);
      temp_warn <= 1'h1;
      over_temp <= 1'h1;
      repeat (3) @(posedge aclk);
      chk(32'({line_sink_on, line_src_on, regulator_en}),
          32'h0000_0000);
      rd_reg(ldwf_pkg::STATUS_OFS);
      chk(32'(rd[ldwf_pkg::ST_OVERTEMP_BIT]), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      over_temp <= 1'h0;
      repeat (3) @(posedge aclk);
      chk(32'({line_sink_on, line_src_on}), 32'h0000_0001);
      chk(32'({regulator_en, temp_ok_n_oe}), 32'h0000_0002);
      $display("test temperature done");
      wrap_up();
   end
endmodule
`default_nettype wire
